// ### verilog/uart_rx_recovery.v
// Receiver back end: start validation, bit voting, stop check, address filtering
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`include "uart_rx_recovery_defines.vh"

// Summary of operation
// - Bit step counts 16 sample states normally, eight in double speed.
// - Each bit is the majority of three consecutive centre samples.
// - First voting sample is number 8 normally, 4 in double speed.
// - Middle voting sample is number 9 normally, 5 in double speed.
// - Every bit through the first stop bit is voted; later stop bits ignored.
// - A first stop bit voted zero in an accepted frame sets the frame error flag.
// - Next start edge accepted right after the stop bit's last vote sample normally, one sample later in double speed.
// - Data plus parity bits total from 5 to 10 per frame.
// - With address filter on, data frames are dropped, never buffered.
// - Frame type is first stop bit for 5-8 bits; for 9, the last bit before the stop (ninth data bit, or parity when enabled).
// - Only receive acceptance depends on the address filter bit.
// - With the filter cleared, data frames are accepted normally.
// - Start is validated by votes on 8,9,10 or 4,5,6; high majority rejects.
// - Sample counter realigns at every validated start bit.
// - Accepted address frames set receive complete like any accepted frame.
module uart_rx_recovery #(
    parameter DATA_BITS_MAX = 10
) (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        rxd,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        irq
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_BITS  = 2'd2;
    localparam ST_GAP   = 2'd3;

    reg [31:0] ctrl_ff;
    reg [15:0] baud_ff;
    reg [15:0] div_ff;
    reg [1:0]  state_ff;
    reg [4:0]  smp_ff;
    reg [3:0]  bit_ff;
    reg [2:0]  win_ff;
    reg [9:0]  shift_ff;
    reg [9:0]  data_ff;
    reg        type_ff;
    reg        ferr_ff;
    reg        rxc_ff;
    reg [2:0]  int_stat_ff;
    reg [2:0]  int_mask_ff;
    reg        aw_ff;
    reg        w_ff;
    reg [7:0]  awaddr_ff;
    reg [31:0] wdata_ff;
    // Strobes travel with the data they qualify; the bus may change them after the handshake
    reg [3:0]  wstrb_ff;

    wire       enable    = ctrl_ff[`CTRL_ENABLE];
    wire       dbl       = ctrl_ff[`CTRL_DOUBLE];
    wire       filt      = ctrl_ff[`CTRL_ADDR_FILT];
    wire [3:0] dbits     = ctrl_ff[`CTRL_SIZE_MSB:`CTRL_SIZE_LSB];
    wire       par_en    = ctrl_ff[`CTRL_PARITY];

    // Data plus parity bits, clamped to the supported range
    function [3:0] clamp_bits;
        input [3:0] d;
        input       p;
        reg   [4:0] t;
        begin
            t = {1'b0, d} + {4'd0, p};
            if (t < {1'b0, `MIN_BITS})
                clamp_bits = `MIN_BITS;
            else if (t > {1'b0, `MAX_BITS})
                clamp_bits = `MAX_BITS;
            else
                clamp_bits = t[3:0];
        end
    endfunction

    wire [3:0] nbits = clamp_bits(dbits, par_en);

    // Vote on three samples: two or more highs give one
    function vote3;
        input [2:0] s;
        begin
            vote3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
        end
    endfunction

    wire [4:0] os_len  = dbl ? `OS_DOUBLE : `OS_NORMAL;
    wire [4:0] v_first = dbl ? `VOTE_FIRST_D : `VOTE_FIRST_N;
    wire [4:0] v_mid   = v_first + 5'd1;
    wire [4:0] v_last  = v_first + 5'd2;
    // Double speed holds off the next start one sample past the last vote
    wire [4:0] gap_end = dbl ? v_last + 5'd1 : v_last;

    wire tick = enable && (div_ff == 16'h0000);
    wire [2:0] win_nxt = {rxd, win_ff[2:1]};
    wire       bit_val = vote3(win_nxt);

    // Stop bit is the bit after all data and parity bits
    wire       at_stop = (bit_ff == nbits);
    // The last bit before the stop carries the frame type in 9-bit frames: the ninth data bit, or the parity bit when parity is on
    wire       nine    = (dbits == 4'd9);
    wire [9:0] frame_nxt = {bit_val, shift_ff[9:1]};

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            div_ff <= 16'h0000;
        else if (!enable || div_ff == 16'h0000)
            div_ff <= baud_ff;
        else
            div_ff <= div_ff - 16'h0001;
    end

    reg  nxt_deliver;
    reg  nxt_drop;
    reg  type_bit;
    always @*
    begin
        type_bit    = nine ? shift_ff[9] : bit_val;
        nxt_deliver = 1'b0;
        nxt_drop    = 1'b0;
        if (tick && state_ff == ST_BITS && smp_ff == v_last && at_stop)
        begin
            // Type one is an address frame; only data frames are filtered
            if (filt && !type_bit)
                nxt_drop = 1'b1;
            else
                nxt_deliver = 1'b1;
        end
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ST_IDLE;
            smp_ff   <= 5'd0;
            bit_ff   <= 4'd0;
            win_ff   <= 3'b111;
            shift_ff <= 10'h000;
        end
        else if (!enable)
        begin
            // Disabling aborts any frame at once
            state_ff <= ST_IDLE;
            smp_ff   <= 5'd0;
            bit_ff   <= 4'd0;
        end
        else if (tick)
        begin
            win_ff <= win_nxt;
            case (state_ff)
                ST_IDLE:
                begin
                    if (!rxd)
                    begin
                        // This tick is sample 1, so the next one is sample 2
                        state_ff <= ST_START;
                        smp_ff   <= 5'd2;
                    end
                end
                ST_START:
                begin
                    smp_ff <= smp_ff + 5'd1;
                    if (smp_ff == v_last)
                    begin
                        if (bit_val)
                            state_ff <= ST_IDLE;
                        else
                        begin
                            state_ff <= ST_BITS;
                            bit_ff   <= 4'd0;
                        end
                    end
                    if (smp_ff == os_len)
                        smp_ff <= 5'd1;
                end
                ST_BITS:
                begin
                    smp_ff <= (smp_ff == os_len) ? 5'd1 : smp_ff + 5'd1;
                    if (smp_ff == v_last)
                    begin
                        if (at_stop)
                            state_ff <= dbl ? ST_GAP : ST_IDLE;
                        else
                        begin
                            shift_ff <= frame_nxt;
                            bit_ff   <= bit_ff + 4'd1;
                        end
                    end
                end
                ST_GAP:
                begin
                    smp_ff <= smp_ff + 5'd1;
                    if (smp_ff + 5'd1 >= gap_end)
                        state_ff <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Align received bits to the LSB for delivery
    wire [9:0] aligned = shift_ff >> (4'd10 - nbits);

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            data_ff <= 10'h000;
            type_ff <= 1'b0;
            ferr_ff <= 1'b0;
        end
        else if (nxt_deliver)
        begin
            data_ff <= aligned;
            type_ff <= type_bit;
            ferr_ff <= ~bit_val;
        end
    end

    // AXI4-Lite slave; address and data taken in either order
    wire wr_go = aw_ff && w_ff && !s_axi_bvalid;
    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_go   = s_axi_arvalid && !s_axi_rvalid;
    wire rd_data = rd_go && (s_axi_araddr[7:0] == `OFS_DATA);

    wire wr_ok = (awaddr_ff == `OFS_CTRL) || (awaddr_ff == `OFS_BAUD) ||
                 (awaddr_ff == `OFS_INT_STAT) || (awaddr_ff == `OFS_INT_MASK);
    wire wr_int_stat = wr_go && (awaddr_ff == `OFS_INT_STAT) && wstrb_ff[0];

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_ff        <= 1'b0;
            w_ff         <= 1'b0;
            awaddr_ff    <= 8'h00;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            ctrl_ff      <= `CTRL_RESET;
            baud_ff      <= `BAUD_RESET;
            int_mask_ff  <= 3'b000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go)
            begin
                aw_ff        <= 1'b0;
                w_ff         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
                // Filter bit touches receive acceptance only; no transmit path here
                if (awaddr_ff == `OFS_CTRL)
                begin
                    if (wstrb_ff[0])
                        ctrl_ff[7:0] <= wdata_ff[7:0];
                    if (wstrb_ff[1])
                        ctrl_ff[15:8] <= wdata_ff[15:8];
                end
                if (awaddr_ff == `OFS_BAUD)
                begin
                    if (wstrb_ff[0])
                        baud_ff[7:0] <= wdata_ff[7:0];
                    if (wstrb_ff[1])
                        baud_ff[15:8] <= wdata_ff[15:8];
                end
                if (awaddr_ff == `OFS_INT_MASK && wstrb_ff[0])
                    int_mask_ff <= wdata_ff[2:0];
            end
        end
    end

    // Set wins over software clear and over a read in the same cycle
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rxc_ff      <= 1'b0;
            int_stat_ff <= 3'b000;
        end
        else
        begin
            if (nxt_deliver)
                rxc_ff <= 1'b1;
            else if (rd_data || !enable)
                rxc_ff <= 1'b0;
            int_stat_ff <= (int_stat_ff & ~(wr_int_stat ? wdata_ff[2:0] : 3'b000))
                         | {nxt_drop, nxt_deliver & ~bit_val, nxt_deliver};
        end
    end

    assign irq = |(int_stat_ff & int_mask_ff);

    reg [31:0] rd_mux;
    always @*
    begin
        case (s_axi_araddr[7:0])
            `OFS_CTRL:     rd_mux = ctrl_ff;
            `OFS_BAUD:     rd_mux = {16'h0000, baud_ff};
            `OFS_STATUS:   rd_mux = {29'd0, (state_ff != ST_IDLE), ferr_ff, rxc_ff};
            `OFS_DATA:     rd_mux = {16'h0000, type_ff, 5'd0, data_ff[9:0]} & 32'h0000_83ff;
            `OFS_INT_STAT: rd_mux = {29'd0, int_stat_ff};
            `OFS_INT_MASK: rd_mux = {29'd0, int_mask_ff};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr[7:0] <= `OFS_INT_MASK &&
                             s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // uart_rx_recovery

// ### verilog/uart_rx_recovery_defines.vh
// Register offsets, field positions, reset values and timing counts for the receiver back end
`ifndef UART_RX_RECOVERY_DEFINES_VH
`define UART_RX_RECOVERY_DEFINES_VH

`define OFS_CTRL        8'h00
`define OFS_BAUD        8'h04
`define OFS_STATUS      8'h08
`define OFS_DATA        8'h0c
`define OFS_INT_STAT    8'h10
`define OFS_INT_MASK    8'h14

`define CTRL_ENABLE     0
`define CTRL_DOUBLE     1
`define CTRL_ADDR_FILT  2
`define CTRL_SIZE_LSB   4
`define CTRL_SIZE_MSB   7
`define CTRL_PARITY     8
`define CTRL_RESET      32'h0000_0081

`define BAUD_RESET      16'h0000

`define STAT_RXC        0
`define STAT_FERR       1
`define STAT_BUSY       2

`define INT_RXC         0
`define INT_FERR        1
`define INT_DROP        2

`define OS_NORMAL       5'd16
`define OS_DOUBLE       5'd8
`define VOTE_FIRST_N    5'd8
`define VOTE_FIRST_D    5'd4
`define MIN_BITS        4'd5
`define MAX_BITS        4'd10

`endif

// ### testbench/uart_rx_recovery_checker.sv
// Register bus handshake checker for the receiver back end
module uart_rx_recovery_checker (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("second write response");
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("second read response");
    property p_ar_ready;
        s_axi_arready == !s_axi_rvalid;
    endproperty
    a_ar_ready: assert property (p_ar_ready) else $error("arready not inverse of rvalid");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_w_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_w_lat: assert property (p_w_lat) else $error("write answer late");
    property p_b_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while response pending");
endmodule // uart_rx_recovery_checker

bind uart_rx_recovery uart_rx_recovery_checker chk_i (.*);

// ### testbench/uart_far_tx.sv
// Behavioural far-end serial transmitter driving the receive line
module uart_far_tx (
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b1;
    // Glitch inverts the centre of the first bit only, to probe the vote
    task automatic send(input logic [9:0] bits, input int n, input logic sv,
                        input int bt, input int st, input int gl);
        int pre;
        pre = (bt - gl) / 2;
        line = 1'b0;
        #(bt);
        for (int i = 0; i < n; i++)
        begin
            line = bits[i];
            if (i == 0 && gl > 0)
            begin
                #(pre);
                line = ~bits[0];
                #(gl);
                line = bits[0];
                #(bt - pre - gl);
            end
            else
                #(bt);
        end
        line = sv;
        #(st);
        line = 1'b1;
    endtask
endmodule // uart_far_tx

// ### testbench/uart_rx_recovery_tb.sv
// Self-checking bench for the receiver back end over its register bus
module uart_rx_recovery_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] all_m = 32'hffff_ffff;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        rxd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [31:0] cur = 32'h81;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    uart_far_tx far (.line(rxd));
    uart_rx_recovery uut (
        .clk_sys(clk_sys), .rstn(rstn), .rxd(rxd),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq)
    );
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic final_report;
        $display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // About 25 frames of at most 12 bits at 32 clocks each, with ample margin
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch++;
            final_report;
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, (a > 8'h14) ? 32'h2 : 32'h0);
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk($sformatf("reg_%h", a), d & m, exp);
        chk("rresp", {30'h0, r}, 32'h0);
    endtask
    // Skipping an unchanged control write lets a frame follow the previous one at once
    task automatic run(input logic [31:0] ctl, input logic [9:0] bits, input int n,
                       input logic sv, input int bt, input int st, input int gl,
                       input logic [31:0] dat, input logic [31:0] stat, input logic [31:0] ist);
        if (ctl !== cur)
            wr(8'h00, ctl);
        cur = ctl;
        #1;
        far.send(bits, n, sv, bt, st, gl);
        repeat (4) @(posedge clk_sys);
        rchk(8'h08, stat, 32'h3);
        rchk(8'h10, ist, 32'h7);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, ist != 0});
        if (stat[0])
            rchk(8'h0c, dat, (n > 8) ? 32'h83ff : 32'h3ff);
        wr(8'h10, 32'h7);
        #1;
        chk("irq", {31'h0, irq}, 32'h0);
        $display("Frame test %h done", bits);
    endtask
    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rchk(8'h00, 32'h81, all_m);
        rchk(8'h04, 32'h0, all_m);
        rchk(8'h08, 32'h0, all_m);
        rchk(8'h10, 32'h0, all_m);
        rchk(8'h14, 32'h0, all_m);
        rd(8'h18, d, r);
        chk("unmapped_rdata", d, 32'h0);
        chk("unmapped_rresp", {30'h0, r}, 32'h2);
        wr(8'h18, 32'h1);
        wr(8'h04, 32'h1);
        wr(8'h14, 32'h0);
        #1;
        far.send(10'h05a, 8, 1'b1, 320, 320, 0);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("irq", {31'h0, irq}, 32'h0);
        wr(8'h14, 32'h7);
        #1;
        chk("irq", {31'h0, irq}, 32'h1);
        rchk(8'h0c, 32'h5a, 32'h3ff);
        wr(8'h10, 32'h7);
        $display("Register test done");
        run(32'h81, 10'h0a5, 8, 1'b1, 320, 320, 0, 32'ha5, 32'h1, 32'h1);
        run(32'h81, 10'h03c, 8, 1'b0, 320, 320, 0, 32'h3c, 32'h3, 32'h3);
        run(32'h81, 10'h055, 8, 1'b1, 320, 320, 10, 32'h55, 32'h1, 32'h1);
        run(32'h81, 10'h055, 8, 1'b1, 320, 320, 120, 32'h54, 32'h1, 32'h1);
        run(32'h81, 10'h0c3, 8, 1'b1, 330, 330, 0, 32'hc3, 32'h1, 32'h1);
        run(32'h81, 10'h0c3, 8, 1'b1, 310, 310, 0, 32'hc3, 32'h1, 32'h1);
        run(32'h83, 10'h0e7, 8, 1'b1, 160, 160, 0, 32'he7, 32'h1, 32'h1);
        run(32'h83, 10'h096, 8, 1'b1, 165, 165, 0, 32'h96, 32'h1, 32'h1);
        run(32'h83, 10'h055, 8, 1'b1, 160, 160, 10, 32'h55, 32'h1, 32'h1);
        run(32'h83, 10'h055, 8, 1'b1, 160, 160, 60, 32'h54, 32'h1, 32'h1);
        #1;
        far.send(10'h0f0, 8, 1'b1, 160, 140, 0);
        run(32'h83, 10'h00f, 8, 1'b1, 160, 160, 0, 32'h0f, 32'h1, 32'h1);
        run(32'h51, 10'h015, 5, 1'b1, 320, 320, 0, 32'h15, 32'h1, 32'h1);
        run(32'h191, 10'h3ab, 10, 1'b1, 320, 640, 0, 32'h83ab, 32'h1, 32'h1);
        run(32'h95, 10'h0ab, 9, 1'b1, 320, 320, 0, 32'h0, 32'h0, 32'h4);
        run(32'h95, 10'h1ab, 9, 1'b1, 320, 320, 0, 32'h81ab, 32'h1, 32'h1);
        run(32'h85, 10'h05a, 8, 1'b0, 320, 320, 0, 32'h0, 32'h0, 32'h4);
        run(32'h85, 10'h05a, 8, 1'b1, 320, 320, 0, 32'h5a, 32'h1, 32'h1);
        run(32'h91, 10'h0ab, 9, 1'b1, 320, 320, 0, 32'hab, 32'h1, 32'h1);
        #1;
        far.send(10'h011, 9, 1'b1, 320, 220, 0);
        run(32'h91, 10'h0ee, 9, 1'b1, 320, 320, 0, 32'hee, 32'h1, 32'h1);
        run(32'h91, 10'h000, 0, 1'b1, 40, 320, 0, 32'h0, 32'h0, 32'h0);
        // A start wrongly accepted would still be shifting bits here, so busy shows it
        rchk(8'h08, 32'h0, 32'h7);
        final_report;
    end
endmodule // uart_rx_recovery_tb
